// file: common/cttd_pkg.sv
// Constants, types and opcode values for the test/swap/trap decoder.
// Assumes the core's fetch unit, register file and program store around it.
package cttd_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned CTTD_ADDR_W = 12;

    // ************************************************************
    // Opcodes and low-nibble operand-mode codes
    // ************************************************************
    localparam logic [7:0] OP_XSUB_XX = 8'h28;
    localparam logic [7:0] OP_XSUB_IV = 8'h29;
    localparam logic [7:0] OP_SWAP_R  = 8'hf0;
    localparam logic [7:0] OP_SWAP_PT = 8'hf1;
    localparam logic [7:0] OP_TRAP    = 8'hf2;
    localparam logic [7:0] OP_WDOG    = 8'h5f;
    localparam logic [3:0] HI_TSTN    = 4'h6;
    localparam logic [3:0] HI_TST     = 4'h7;
    localparam logic [3:0] LO_RR      = 4'h2;
    localparam logic [3:0] LO_RIR     = 4'h3;
    localparam logic [3:0] LO_FF      = 4'h4;
    localparam logic [3:0] LO_FIR     = 4'h5;
    localparam logic [3:0] LO_FIM     = 4'h6;
    localparam logic [3:0] LO_IRIM    = 4'h7;
    localparam logic [3:0] LO_XX      = 4'h8;
    localparam logic [3:0] LO_XIM     = 4'h9;

    // ************************************************************
    // Flag byte layout
    // ************************************************************
    localparam int unsigned FLG_C = 7;
    localparam int unsigned FLG_Z = 6;
    localparam int unsigned FLG_S = 5;
    localparam int unsigned FLG_V = 4;
    localparam int unsigned FLG_D = 3;
    localparam int unsigned FLG_H = 2;

    // ************************************************************
    // Cycle counts
    // ************************************************************
    localparam logic [2:0] F_SHORT  = 3'h2;
    localparam logic [2:0] F_FULL   = 3'h3;
    localparam logic [2:0] F_EXT    = 3'h4;
    localparam logic [2:0] F_ONE    = 3'h1;
    localparam logic [2:0] E_DIR    = 3'h3;
    localparam logic [2:0] E_IND    = 3'h4;
    localparam logic [2:0] E_EXT    = 3'h3;
    localparam logic [2:0] E_SWAP_D = 3'h2;
    localparam logic [2:0] E_SWAP_I = 3'h3;
    localparam logic [2:0] E_TRAP   = 3'h6;
    localparam logic [2:0] E_WDOG   = 3'h2;

    // Stack offsets used by the trap push
    localparam logic [11:0] SP_PC_OFS  = 12'h002;
    localparam logic [11:0] SP_FLG_OFS = 12'h003;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        CLS_NONE, CLS_XSUB, CLS_SWAP, CLS_TSTN, CLS_TST, CLS_TRAP, CLS_WDOG
    } cttd_cls_e;

    typedef enum logic [1:0] {
        ALU_SUB, ALU_AND, ALU_ANDN, ALU_SWAP
    } cttd_alu_e;

    typedef enum logic [2:0] {
        M_NONE, M_R4, M_R8, M_IR4, M_IR8, M_IMM, M_EXT
    } cttd_mode_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } cttd_state_e;

    typedef struct packed {
        cttd_cls_e  cls;
        cttd_alu_e  alu;
        cttd_mode_e dm;
        cttd_mode_e sm;
        logic [2:0] fetch;
        logic [2:0] exec;
    } cttd_dec_s;

endpackage : cttd_pkg

// file: common/cttd_alu_if.sv
// Interface between the sequencer and its flag/result unit.
// Assumes both ends sit on the same clock; the path is combinational.
`timescale 1ns/100ps
`default_nettype none
interface cttd_alu_if;
    import cttd_pkg::*;
    cttd_alu_e  op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] flags_in;
    logic [7:0] result;
    logic [7:0] flags_out;

    modport seq (output op, a, b, flags_in, input result, flags_out);
    modport alu (input op, a, b, flags_in, output result, flags_out);
endinterface : cttd_alu_if
`default_nettype wire

// file: verilog/cttd_alu.sv
// Result and flag unit for subtract, mask tests and nibble swap.
// Assumes operands are stable for the cycle in which they are used.
`timescale 1ns/100ps
`default_nettype none
module cttd_alu (
    cttd_alu_if.alu  p
);
    import cttd_pkg::*;

    // ************************************************************
    // Combinational result and flags
    // ************************************************************
    logic [7:0] res;
    logic [8:0] diff;

    // Borrow comes from the ninth bit of a zero-extended difference
    assign diff = {1'b0, p.a} - {1'b0, p.b};

    always_comb begin
        res = 8'h00;
        p.flags_out = p.flags_in;
        case (p.op)
            ALU_SUB: begin
                res = diff[7:0];
                p.flags_out[FLG_C] = diff[8];
                p.flags_out[FLG_V] = (p.a[7] ^ p.b[7])
                                   & (res[7] ^ p.a[7]);
                p.flags_out[FLG_D] = 1'b1;
                p.flags_out[FLG_H] = p.a[3:0] < p.b[3:0];
            end
            ALU_AND: begin
                res = p.a & p.b;
                p.flags_out[FLG_V] = 1'b0;
            end
            ALU_ANDN: begin
                res = ~p.a & p.b;
                p.flags_out[FLG_V] = 1'b0;
            end
            ALU_SWAP: begin
                // C and V are undefined; holding them costs nothing
                res = {p.a[3:0], p.a[7:4]};
            end
            default: res = 8'h00;
        endcase
        p.flags_out[FLG_Z] = (res == 8'h00);
        p.flags_out[FLG_S] = res[7];
    end

    assign p.result = res;
endmodule : cttd_alu
`default_nettype wire

// file: verilog/cttd_core.sv
// Decode and execute sequencer for extended subtract, nibble swap,
// mask tests, software trap and watchdog refresh.
// Assumes the register file returns read data in the cycle after o_rf_rd,
// and the program store likewise after o_pm_rd.
`timescale 1ns/100ps
`default_nettype none
module cttd_core #(
    parameter int unsigned ADDR_W = cttd_pkg::CTTD_ADDR_W
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic        i_issue,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [23:0] i_opnd,
    input  wire logic [7:0]  i_wr_base,
    input  wire logic [7:0]  i_flags,
    input  wire logic [11:0] i_sp,
    input  wire logic [15:0] i_pc,
    input  wire logic [7:0]  i_rf_rdata,
    input  wire logic [7:0]  i_pm_rdata,
    output logic             o_hit,
    output logic [2:0]       o_fetch_cycles,
    output logic             o_busy,
    output logic             o_rf_rd,
    output logic             o_rf_wr,
    output logic [11:0]      o_rf_addr,
    output logic [7:0]       o_rf_wdata,
    output logic             o_pm_rd,
    output logic [15:0]      o_pm_addr,
    output logic             o_done,
    output logic             o_flags_we,
    output logic [7:0]       o_flags,
    output logic             o_sp_we,
    output logic [11:0]      o_sp,
    output logic             o_pc_we,
    output logic [15:0]      o_pc,
    output logic             o_wdog_refresh
);
    import cttd_pkg::*;

    // Address arithmetic below is written for a 12-bit register space
    if (ADDR_W != CTTD_ADDR_W) begin : g_chk
        $error("cttd_core: ADDR_W must be 12");
    end

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic cttd_dec_s decode(input logic [7:0] op);
        cttd_dec_s d;
        d = '{CLS_NONE, ALU_AND, M_NONE, M_NONE, 3'h0, 3'h0};
        case (op)
            OP_XSUB_XX, OP_XSUB_IV: begin
                d = '{CLS_XSUB, ALU_SUB, M_EXT,
                      (op == OP_XSUB_IV) ? M_IMM : M_EXT,
                      F_EXT, E_EXT};
            end
            OP_SWAP_R:  d = '{CLS_SWAP, ALU_SWAP, M_R8, M_NONE,
                              F_SHORT, E_SWAP_D};
            OP_SWAP_PT: d = '{CLS_SWAP, ALU_SWAP, M_IR8, M_NONE,
                              F_SHORT, E_SWAP_I};
            OP_TRAP:    d = '{CLS_TRAP, ALU_AND, M_NONE, M_NONE,
                              F_SHORT, E_TRAP};
            OP_WDOG:    d = '{CLS_WDOG, ALU_AND, M_NONE, M_NONE,
                              F_ONE, E_WDOG};
            default: begin
                if (op[7:4] == HI_TSTN || op[7:4] == HI_TST) begin
                    d.cls = (op[7:4] == HI_TSTN) ? CLS_TSTN : CLS_TST;
                    d.alu = (op[7:4] == HI_TSTN) ? ALU_ANDN : ALU_AND;
                    // Modes per low nibble
                    case (op[3:0])
                        LO_RR:   d = '{d.cls, d.alu, M_R4, M_R4,
                                       F_SHORT, E_DIR};
                        LO_RIR:  d = '{d.cls, d.alu, M_R4, M_IR4,
                                       F_SHORT, E_IND};
                        LO_FF:   d = '{d.cls, d.alu, M_R8, M_R8,
                                       F_FULL, E_DIR};
                        LO_FIR:  d = '{d.cls, d.alu, M_R8, M_IR8,
                                       F_FULL, E_IND};
                        LO_FIM:  d = '{d.cls, d.alu, M_R8, M_IMM,
                                       F_FULL, E_DIR};
                        LO_IRIM: d = '{d.cls, d.alu, M_IR8, M_IMM,
                                       F_FULL, E_IND};
                        LO_XX:   d = '{d.cls, d.alu, M_EXT, M_EXT,
                                       F_EXT, E_EXT};
                        LO_XIM:  d = '{d.cls, d.alu, M_EXT, M_IMM,
                                       F_EXT, E_EXT};
                        default: d.cls = CLS_NONE;
                    endcase
                end
            end
        endcase
        return d;
    endfunction : decode

    // Location of an operand or of its pointer, by mode
    function automatic logic [11:0] loc(input cttd_mode_e m,
                                        input logic [11:0] f,
                                        input logic [7:0]  wb);
        logic [11:0] a;
        a = 12'h000;
        case (m)
            M_R4, M_IR4: a = {wb, f[3:0]};
            M_R8, M_IR8: a = {4'h0, f[7:0]};
            M_EXT:       a = f;
            default:     a = 12'h000;
        endcase
        return a;
    endfunction : loc

    cttd_dec_s   dec_in;
    assign dec_in         = decode(i_opcode);
    assign o_hit          = (dec_in.cls != CLS_NONE);
    assign o_fetch_cycles = dec_in.fetch;

    // ************************************************************
    // Sequencer state
    // ************************************************************
    cttd_state_e state_r;
    logic [2:0]  step_r;
    logic [7:0]  op_r;
    logic [23:0] opnd_r;
    logic [7:0]  wb_r;
    logic        last;
    cttd_dec_s   dec;

    assign dec    = decode(op_r);
    assign last   = (state_r == ST_EXEC) && (step_r == dec.exec - 3'h1);
    assign o_busy = (state_r == ST_EXEC);

    // Requests while busy are ignored; the fetch unit waits on o_busy
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            step_r  <= 3'h0;
        end else if (state_r == ST_IDLE) begin
            step_r <= 3'h0;
            if (i_issue && o_hit) begin
                state_r <= ST_EXEC;
            end
        end else if (last) begin
            state_r <= ST_IDLE;
            step_r  <= 3'h0;
        end else begin
            step_r <= step_r + 3'h1;
        end
    end

    // Instruction latch
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            op_r   <= 8'h00;
            opnd_r <= 24'h000000;
            wb_r   <= 8'h00;
        end else if (state_r == ST_IDLE && i_issue && o_hit) begin
            op_r   <= i_opcode;
            opnd_r <= i_opnd;
            wb_r   <= i_wr_base;
        end
    end

    // ************************************************************
    // Operand fields and addresses
    // ************************************************************
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [11:0] dst_f;
    logic [11:0] src_f;
    logic [7:0]  imm;
    logic        dind;
    logic        sind;
    logic        ind;
    logic [2:0]  k;
    logic [7:0]  ptr_r;
    logic [7:0]  ptr_now;
    logic [7:0]  dst_r;
    logic [7:0]  vhi_r;
    logic [11:0] dst_a;
    logic [11:0] src_a;
    logic [15:0] vec_a;

    assign b1 = opnd_r[23:16];
    assign b2 = opnd_r[15:8];
    assign b3 = opnd_r[7:0];

    // Field placement follows the operand-mode byte layouts
    always_comb begin
        dst_f = {4'h0, b1};
        src_f = {4'h0, b2};
        imm   = b2;
        case (dec.dm)
            M_R4:  begin
                dst_f = {8'h00, b1[7:4]};
                src_f = {8'h00, b1[3:0]};
            end
            M_EXT: begin
                dst_f = {b2[3:0], b3};
                src_f = {b1, b2[7:4]};
                imm   = b1;
            end
            default: begin
                if (dec.sm == M_R8 || dec.sm == M_IR8) begin
                    dst_f = {4'h0, b2};
                    src_f = {4'h0, b1};
                end
            end
        endcase
    end

    assign dind    = (dec.dm == M_IR4) || (dec.dm == M_IR8);
    assign sind    = (dec.sm == M_IR4) || (dec.sm == M_IR8);
    assign ind     = dind || sind;
    // Relative step: the pointer read, if any, comes first
    assign k       = step_r - {2'b00, ind};
    // A destination pointer is used straight off the bus in the cycle it arrives; a source pointer comes from ptr_r
    assign ptr_now = (step_r == 3'h1) ? i_rf_rdata : ptr_r;
    assign dst_a   = dind ? {4'h0, ptr_now}
                          : loc(dec.dm, dst_f, wb_r);
    assign src_a   = sind ? {4'h0, ptr_r}
                          : loc(dec.sm, src_f, wb_r);
    assign vec_a   = {7'h00, b1, 1'b0};

    // Pointer, destination and vector-high captures
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ptr_r <= 8'h00;
            dst_r <= 8'h00;
            vhi_r <= 8'h00;
        end else if (o_busy) begin
            if (ind && step_r == 3'h1) ptr_r <= i_rf_rdata;
            if (k == 3'h1) dst_r <= i_rf_rdata;
            if (dec.cls == CLS_TRAP && step_r == 3'h4) vhi_r <= i_pm_rdata;
        end
    end

    // ************************************************************
    // Bus strobes and result unit
    // ************************************************************
    cttd_alu_if alu_b ();
    cttd_alu u_alu (.p(alu_b));

    assign alu_b.op       = dec.alu;
    assign alu_b.flags_in = i_flags;
    assign alu_b.a        = (dec.cls == CLS_SWAP) ? i_rf_rdata : dst_r;
    assign alu_b.b        = (dec.sm == M_IMM) ? imm : i_rf_rdata;

    always_comb begin
        o_rf_rd    = 1'b0;
        o_rf_wr    = 1'b0;
        o_rf_addr  = 12'h000;
        o_rf_wdata = 8'h00;
        o_pm_rd    = 1'b0;
        o_pm_addr  = 16'h0000;
        if (o_busy) begin
            case (dec.cls)
                CLS_TRAP: begin
                    // Push PC high/low, then flags below it
                    case (step_r)
                        3'h0: begin
                            o_rf_wr    = 1'b1;
                            o_rf_addr  = i_sp - SP_PC_OFS;
                            o_rf_wdata = i_pc[15:8];
                        end
                        3'h1: begin
                            o_rf_wr    = 1'b1;
                            o_rf_addr  = i_sp - SP_PC_OFS + 12'h001;
                            o_rf_wdata = i_pc[7:0];
                        end
                        3'h2: begin
                            o_rf_wr    = 1'b1;
                            o_rf_addr  = i_sp - SP_FLG_OFS;
                            o_rf_wdata = i_flags;
                        end
                        3'h3: begin
                            o_pm_rd   = 1'b1;
                            o_pm_addr = vec_a;
                        end
                        3'h4: begin
                            o_pm_rd   = 1'b1;
                            o_pm_addr = vec_a + 16'h0001;
                        end
                        default: o_pm_rd = 1'b0;
                    endcase
                end
                CLS_WDOG, CLS_NONE: o_rf_rd = 1'b0;
                default: begin
                    if (ind && step_r == 3'h0) begin
                        o_rf_rd   = 1'b1;
                        o_rf_addr = loc(dind ? dec.dm : dec.sm,
                                        dind ? dst_f : src_f, wb_r);
                    end else if (k == 3'h0) begin
                        o_rf_rd   = 1'b1;
                        o_rf_addr = dst_a;
                    end else if (k == 3'h1 && dec.cls == CLS_SWAP) begin
                        o_rf_wr    = 1'b1;
                        o_rf_addr  = dst_a;
                        o_rf_wdata = alu_b.result;
                    end else if (k == 3'h1) begin
                        o_rf_rd   = (dec.sm != M_IMM);
                        o_rf_addr = src_a;
                    end else if (k == 3'h2 && dec.cls == CLS_XSUB) begin
                        o_rf_wr    = 1'b1;
                        o_rf_addr  = dst_a;
                        o_rf_wdata = alu_b.result;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Commit: one pulse after the last execute cycle
    // ************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_done     <= 1'b0;
            o_flags_we <= 1'b0;
            o_flags    <= 8'h00;
            o_sp_we    <= 1'b0;
            o_sp       <= 12'h000;
            o_pc_we    <= 1'b0;
            o_pc       <= 16'h0000;
        end else begin
            o_done     <= last;
            // Trap and refresh leave the flags alone
            o_flags_we <= last && dec.cls != CLS_TRAP
                               && dec.cls != CLS_WDOG;
            o_sp_we    <= last && dec.cls == CLS_TRAP;
            o_pc_we    <= last && dec.cls == CLS_TRAP;
            if (last) begin
                o_flags <= alu_b.flags_out;
                o_sp    <= i_sp - SP_FLG_OFS;
                o_pc    <= {vhi_r, i_pm_rdata};
            end
        end
    end

    // Refresh pulse to the watchdog, once per opcode
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_wdog_refresh <= 1'b0;
        end else begin
            o_wdog_refresh <= o_busy && dec.cls == CLS_WDOG
                              && step_r == 3'h0;
        end
    end
endmodule : cttd_core
`default_nettype wire

// file: verification/cttd_core_props.sv
// Checker for the test/swap/trap decoder top module.
// Assumes it is bound onto cttd_core and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cttd_core_props (
    input wire logic       i_clk_sys,
    input wire logic       i_srst,
    input wire logic       i_issue,
    input wire logic [7:0] i_opcode,
    input wire logic       o_hit,
    input wire logic [2:0] o_fetch_cycles,
    input wire logic       o_busy,
    input wire logic       o_done,
    input wire logic       o_flags_we,
    input wire logic [7:0] o_flags,
    input wire logic       o_wdog_refresh
);
    // ********
    // Decode and timing checks, quiet while reset is high
    // ********
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    wire logic acc = i_issue && o_hit && !o_busy;  // Request taken
    a_hit_decode: assert property (o_hit == (i_opcode inside
        {8'h28, 8'h29, [8'hf0:8'hf2], 8'h5f, [8'h62:8'h69], [8'h72:8'h79]}))
        else $error("hit decode");
    a_fetch_ext: assert property (i_opcode inside
        {8'h28, 8'h29, 8'h68, 8'h69, 8'h78, 8'h79} |-> o_fetch_cycles == 3'h4)
        else $error("ext fetch");
    a_fetch_short: assert property (i_opcode inside
        {8'h62, 8'h63, 8'h72, 8'h73, 8'hf0, 8'hf1, 8'hf2}
        |-> o_fetch_cycles == 3'h2) else $error("short fetch");
    a_fetch_full: assert property (i_opcode inside
        {[8'h64:8'h67], [8'h74:8'h77]} |-> o_fetch_cycles == 3'h3)
        else $error("full fetch");
    a_fetch_one: assert property (i_opcode == 8'h5f
        |-> o_fetch_cycles == 3'h1) else $error("one byte fetch");
    a_sub_end: assert property (acc
        && i_opcode inside {8'h28, 8'h29}
        |-> ##4 (o_done && o_flags_we && o_flags[3])) else $error("sub");
    a_ind_time: assert property (acc && i_opcode inside
        {8'h63, 8'h65, 8'h67, 8'h73, 8'h75, 8'h77} |-> ##4 !o_done ##1 o_done)
        else $error("indirect time");
    a_swap_time: assert property (acc && i_opcode == 8'hf0 |->
        ##2 !o_done ##1 (o_done && o_flags_we)) else $error("swap time");
    a_trap_seq: assert property (acc && i_opcode == 8'hf2 |=>
        o_busy [*6] ##1 (o_done && !o_flags_we)) else $error("trap time");
    a_refresh_pulse: assert property (acc && i_opcode == 8'h5f |->
        ##2 o_wdog_refresh ##1 (o_done && !o_flags_we))
        else $error("refresh");
endmodule : cttd_core_props
bind cttd_core cttd_core_props u_cttd_core_props (.i_clk_sys, .i_srst,
    .i_issue, .i_opcode, .o_hit, .o_fetch_cycles, .o_busy, .o_done,
    .o_flags_we, .o_flags, .o_wdog_refresh);
`default_nettype wire

// file: verification/tb_cttd_core.sv
// Self-checking bench for the test/swap/trap decoder.
// Assumes a behavioural register file and program store answer it.
`timescale 1ns/100ps
`default_nettype none
module tb_cttd_core;
    logic        i_clk_sys = 0, i_srst = 1, i_issue = 0, wd;
    logic [7:0]  i_opcode = 0, i_wr_base = 8'h0a, i_flags = 8'hfc;
    logic [7:0]  i_rf_rdata = 0, i_pm_rdata = 0, mem [4096];
    logic [23:0] i_opnd = 0;
    logic [11:0] i_sp = 12'h100;
    logic [15:0] i_pc = 16'h1234;
    wire logic   o_hit, o_busy, o_rf_rd, o_rf_wr, o_pm_rd, o_done, o_sp_we;
    wire logic   o_flags_we, o_pc_we, o_wdog_refresh;
    wire logic [2:0]  o_fetch_cycles;
    wire logic [7:0]  o_rf_wdata, o_flags;
    wire logic [11:0] o_rf_addr, o_sp;
    wire logic [15:0] o_pm_addr, o_pc;
    int          num_errors = 0, cmp_count = 0, k;
    cttd_core u_cttd_core (.i_clk_sys, .i_srst, .i_issue, .i_opcode, .i_opnd,
        .i_wr_base, .i_flags, .i_sp, .i_pc, .i_rf_rdata, .i_pm_rdata, .o_hit,
        .o_fetch_cycles, .o_busy, .o_rf_rd, .o_rf_wr, .o_rf_addr, .o_rf_wdata,
        .o_pm_rd, .o_pm_addr, .o_done, .o_flags_we, .o_flags, .o_sp_we, .o_sp,
        .o_pc_we, .o_pc, .o_wdog_refresh);
    initial forever #5 i_clk_sys = ~i_clk_sys;
    // Stores answer a cycle after a read; idle lines toggle so stale data
    // can never pass for an answer
    always @(posedge i_clk_sys) begin
        if (o_rf_wr) mem[o_rf_addr] <= o_rf_wdata;
        i_rf_rdata <= #1 o_rf_rd ? mem[o_rf_addr] : ~i_rf_rdata;
        i_pm_rdata <= #1 o_pm_rd ? o_pm_addr[7:0] ^ 8'h5a : ~i_pm_rdata;
    end
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One instruction, with a bounded wait for its completion pulse
    task automatic run(input logic [7:0] op, input logic [23:0] od, int n);
        @(posedge i_clk_sys) #1;
        i_opcode = op;
        i_opnd = od;
        i_issue = 1;
        @(posedge i_clk_sys) #1;
        i_issue = 0;
        wd = 0;
        for (k = 0; k < 20 && o_done !== 1'b1; k++) begin
            wd |= o_wdog_refresh;
            @(posedge i_clk_sys) #1;
        end
        chk("exec cycles", 16'(k), 16'(n));
    endtask : run
    task automatic t_sub();
        mem[12'h234] = 8'h35;
        mem[12'h1c7] = 8'h47;
        run(8'h28, 24'h1c7234, 3);
        chk("sub", 16'(mem[12'h234]), 16'h00ee);
        chk("sub flags", 16'(o_flags[7:2]), 16'h002b);
        run(8'h29, 24'hee0234, 3);
        chk("sub zero", 16'({mem[12'h234], o_flags[7:2]}),
            16'h0012);
    endtask : t_sub
    // Both mask tests: opcode, operands, expected flags 7..2
    task automatic t_mask();
        logic [39:0] tc [12] = '{40'h72_350000_2b, 40'h62_350000_23,
            40'h76_a30f00_33, 40'h66_a30f00_23, 40'h73_360000_2b,
            40'h78_0a50a3_2b, 40'h69_f000a3_33, 40'h74_a5a300_2b,
            40'h65_a6a300_23, 40'h77_a6f000_2b, 40'h79_0f00a3_33,
            40'h68_0a50a3_23};
        mem[12'h0a3] = 8'hf0;
        mem[12'h0a5] = 8'h8f;
        mem[12'h0a6] = 8'ha5;
        foreach (tc[i]) begin
            run(tc[i][39:32], tc[i][31:8],
                (tc[i][39:32] inside {8'h63, 8'h65, 8'h67, 8'h73,
                8'h75, 8'h77}) ? 4 : 3);
            chk("mask", 16'(o_flags[7:2]), 16'(tc[i][7:0]));
            chk("mask dst", 16'(mem[12'h0a3]), 16'h00f0);
        end
    endtask : t_mask
    task automatic t_swap();
        mem[12'h0c1] = 8'h80;
        mem[12'h0c2] = 8'hc1;
        run(8'hf0, 24'hc10000, 2);
        chk("swap", 16'({o_flags[6:5], o_flags[3:2], mem[12'h0c1]}),
            16'h0308);
        run(8'hf1, 24'hc20000, 3);
        chk("swap ind", 16'(mem[12'h0c1]), 16'h0080);
    endtask : t_swap
    task automatic t_trap();
        run(8'hf2, 24'h070000, 6);
        chk("pc push", {mem[12'h0fe], mem[12'h0ff]}, 16'h1234);
        chk("flag push", 16'(mem[12'h0fd]), 16'h00fc);
        chk("sp", 16'({o_sp_we, o_pc_we, o_sp}), 16'h30fd);
        chk("pc", o_pc, 16'h5455);
        run(8'h5f, 24'h0, 2);
        chk("refresh", 16'({wd, o_flags_we}), 16'h0002);
    endtask : t_trap
    // Main sequence after a 20-cycle reset
    initial begin
        repeat (20) @(posedge i_clk_sys);
        #1 i_srst = 0;
        t_sub();
        t_mask();
        t_swap();
        t_trap();
        complete_run();
    end
    // Run needs about 115 cycles; cut a hang short well after that
    initial begin
        #5000;
        num_errors++;
        complete_run();
    end
    task automatic complete_run();
        $display("Comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
endmodule : tb_cttd_core
`default_nettype wire
